// file: arsq_pkg.sv
// constants, state codes and state layout of the reclose sequencer
package arsq_pkg;
   // clock and millisecond tick
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned TICK_PERIOD_NS = 1_000_000;
   localparam int unsigned TICK_CYCLES =
      (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // sizes
   localparam int unsigned NREQ = 5;
   localparam int unsigned NSHOT = 4;
   localparam int unsigned DT_DEPTH = 20;
   localparam int unsigned NEV = 5;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SHOTS = 8'h04;
   localparam logic [7:0] OFS_ARC = 8'h08;
   localparam logic [7:0] OFS_RECLAIM = 8'h0C;
   localparam logic [7:0] OFS_STATE = 8'h10;
   localparam logic [7:0] OFS_IRQ_STS = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
   localparam logic [7:0] OFS_CMD = 8'h1C;
   localparam logic [7:0] OFS_DT_FIRST = 8'h40;
   localparam logic [7:0] OFS_DT_LAST = 8'h8C;
   localparam logic [5:0] DT_WORD_BASE = 6'h10;
   // control bit positions and reset value
   localparam int unsigned CTRL_EN = 0;
   localparam int unsigned CTRL_ARC = 1;
   localparam int unsigned CTRL_RCL_FINAL = 2;
   localparam int unsigned CTRL_ARR_LOCK = 3;
   localparam logic [3:0] CTRL_RESET = 4'h9;
   // event bit positions
   localparam int unsigned EV_START = 0;
   localparam int unsigned EV_SHOT = 1;
   localparam int unsigned EV_LOCK = 2;
   localparam int unsigned EV_OK = 3;
   localparam int unsigned EV_FAIL = 4;
   // sequencer states, gray along the usual path
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_ARC = 3'b001,
      S_OPENW = 3'b011,
      S_DEAD = 3'b010,
      S_CLOSEW = 3'b110,
      S_RECL = 3'b111,
      S_ARRECL = 3'b101,
      S_LOCK = 3'b100
   } arsq_fsm_t;
   // whole module state
   typedef struct packed {
      arsq_fsm_t fsm;
      logic [2:0] req;
      logic [1:0] shot;
      logic [15:0] tmr;
      logic [15:0] div;
      logic trip_done;
      logic sw_rst;
      logic [3:0] ctrl;
      logic [14:0] shots;
      logic [15:0] arc;
      logic [15:0] recl;
      logic [15:0] arrecl;
      logic [4:0] sts;
      logic [4:0] mask;
      logic ack;
      logic [31:0] rdata;
   } arsq_state_t;
endpackage

// file: arsq_dtmem.sv
// dead time table, one word per request and shot, two read ports
`timescale 1ns/100ps
module arsq_dtmem (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // write port
   input wire logic we_in,
   input wire logic [4:0] waddr_in,
   input wire logic [15:0] wdata_in,
   // read ports, data one cycle after address
   input wire logic [4:0] raddr_a_in,
   output logic [15:0] rdata_a_out,
   input wire logic [4:0] raddr_b_in,
   output logic [15:0] rdata_b_out
);
   import arsq_pkg::*;
   logic [15:0] mem [DT_DEPTH];

   // cleared at reset so no unknown time ever reaches the sequencer
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         for (int i = 0; i < DT_DEPTH; i++) begin
            mem[i] <= 16'h0000;
         end
         rdata_a_out <= 16'h0000;
         rdata_b_out <= 16'h0000;
      end else begin
         if (we_in && waddr_in < 5'(DT_DEPTH)) begin
            mem[waddr_in] <= wdata_in;
         end
         rdata_a_out <= (raddr_a_in < 5'(DT_DEPTH)) ? mem[raddr_a_in]
                                                   : 16'h0000;
         rdata_b_out <= (raddr_b_in < 5'(DT_DEPTH)) ? mem[raddr_b_in]
                                                   : 16'h0000;
      end
   end
endmodule // arsq_dtmem

// file: arsq_top.sv
// auto-reclose sequencer with avalon register slave
`timescale 1ns/100ps
module arsq_top #(
   parameter int unsigned TICK_CYCLES = arsq_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic RESET_IN,
   // avalon-mm slave
   input wire logic [7:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   output logic [31:0] AVS_READDATA_OUT,
   output logic AVS_WAITREQUEST_OUT,
   output logic IRQ_OUT,
   // protection side requests
   input wire logic [arsq_pkg::NREQ-1:0] RECLOSE_REQ_IN,
   input wire logic CRITICAL_REQ_IN,
   input wire logic HIGHSET_OC_IN,
   input wire logic MANUAL_RESET_IN,
   // breaker object
   input wire logic BRK_OPEN_IN,
   input wire logic BRK_CLOSED_IN,
   input wire logic BRK_WAIT_IN,
   input wire logic BRK_ACK_OK_IN,
   input wire logic BRK_ACK_FAIL_IN,
   output logic BRK_OPEN_CMD_OUT,
   output logic BRK_CLOSE_CMD_OUT,
   // indications
   output logic RUNNING_OUT,
   output logic FINAL_TRIP_OUT,
   output logic LOCKOUT_OUT,
   output logic RECLAIM_OUT,
   output logic [arsq_pkg::NREQ-1:0] REQUESTED_OUT,
   output logic [arsq_pkg::NSHOT-1:0] SHOT_RUN_OUT
);
   import arsq_pkg::*;
   arsq_state_t st, next_st;
   logic [2:0] req_shot_cnt [NREQ];
   logic [2:0] pri_idx, cur_shots;
   logic [15:0] dead_ms, mem_bus_rd;
   logic [4:0] ev, clr;
   logic any_req, running, abort, lock_exit, arc_go, more, tick;
   logic access, done, mem_sel;
   logic [4:0] mem_bus_idx;

   // shot count field per request
   genvar g;
   for (g = 0; g < NREQ; g++) begin : g_shots
      assign req_shot_cnt[g] = st.shots[3*g +: 3];
   end

   always_comb begin
      pri_idx = 3'd0;
      for (int i = NREQ - 1; i >= 0; i--) begin
         if (RECLOSE_REQ_IN[i]) begin
            pri_idx = 3'(i);
         end
      end
   end
   assign any_req = |RECLOSE_REQ_IN;
   assign cur_shots = req_shot_cnt[pri_idx];
   // own arcing delay only when chosen and nonzero
   assign arc_go = st.ctrl[CTRL_ARC] && st.arc != 16'h0000;
   assign more = ({1'b0, st.shot} + 3'd1) < cur_shots && st.shot != 2'd3;
   assign running = st.fsm inside {S_ARC, S_OPENW, S_DEAD, S_CLOSEW, S_RECL};
   // high-set interlock acts in any state
   assign abort = HIGHSET_OC_IN || (CRITICAL_REQ_IN && running) ||
                  (BRK_ACK_FAIL_IN && running);
   // leave lock on reset or closed breaker, only once cause is gone
   // no other way out of lock-out
   assign lock_exit = (MANUAL_RESET_IN || st.sw_rst ||
                       (BRK_CLOSED_IN && st.trip_done)) &&
                      !CRITICAL_REQ_IN && !HIGHSET_OC_IN;

   // bus handshake: one wait cycle, data registered in it
   assign access = AVS_READ_IN || AVS_WRITE_IN;
   assign done = access && st.ack;
   assign AVS_WAITREQUEST_OUT = access && !st.ack;
   assign mem_sel = AVS_ADDRESS_IN >= OFS_DT_FIRST &&
                    AVS_ADDRESS_IN <= OFS_DT_LAST;
   assign mem_bus_idx = 5'(AVS_ADDRESS_IN[7:2] - DT_WORD_BASE);
   assign AVS_READDATA_OUT = mem_sel ? {16'h0000, mem_bus_rd} : st.rdata;

   // dead time table; sequencer port follows the next request and shot
   arsq_dtmem u_dtmem (
      .clk_in(CLK_IN),
      .reset_in(RESET_IN),
      .we_in(AVS_WRITE_IN && done && mem_sel),
      .waddr_in(mem_bus_idx),
      .wdata_in(AVS_WRITEDATA_IN[15:0]),
      .raddr_a_in(mem_bus_idx),
      .rdata_a_out(mem_bus_rd),
      .raddr_b_in({next_st.req[2:0], next_st.shot}),
      .rdata_b_out(dead_ms)
   );

   // next state of everything
   always_comb begin
      next_st = st;
      ev = 5'h00;
      clr = 5'h00;
      // millisecond tick; limits the timers to 65 s
      tick = (st.div == 16'(TICK_CYCLES - 1));
      next_st.div = tick ? 16'h0000 : st.div + 16'h0001;
      if (tick && st.tmr != 16'hFFFF) begin
         next_st.tmr = st.tmr + 16'h0001;
      end
      next_st.sw_rst = 1'b0;
      unique case (st.fsm)
         S_IDLE: begin
            if (any_req && st.ctrl[CTRL_EN]) begin
               next_st.req = pri_idx;
               next_st.shot = 2'd0;
               ev[EV_START] = 1'b1;
               next_st.fsm = (cur_shots == 3'd0) ? S_LOCK :
                             arc_go ? S_ARC : S_OPENW;
            end
         end
         S_ARC: begin
            if (st.tmr >= st.arc) begin
               next_st.fsm = S_OPENW;
            end
         end
         S_OPENW: begin
            // stay while the object has not opened
            // zero dead time goes straight to closing
            if (BRK_OPEN_IN) begin
               next_st.fsm = (dead_ms == 16'h0000) ? S_CLOSEW : S_DEAD;
            end
         end
         S_DEAD: begin
            // line kept dead for the shot's dead time
            if (st.tmr >= dead_ms) begin
               next_st.fsm = S_CLOSEW;
            end
         end
         S_CLOSEW: begin
            if (BRK_ACK_OK_IN) begin
               next_st.fsm = (st.recl != 16'h0000) ? S_RECL :
                             (st.arrecl != 16'h0000) ? S_ARRECL : S_IDLE;
               ev[EV_OK] = (st.recl == 16'h0000);
            end
         end
         S_RECL: begin
            if (any_req) begin
               // failed shot, next shot or final trip
               if (!st.ctrl[CTRL_RCL_FINAL] && more) begin
                  next_st.req = pri_idx;
                  next_st.shot = st.shot + 2'd1;
                  next_st.fsm = arc_go ? S_ARC : S_OPENW;
                  ev[EV_SHOT] = 1'b1;
               end else begin
                  next_st.fsm = S_LOCK;
               end
            end else if (st.tmr >= st.recl) begin
               next_st.fsm = (st.arrecl != 16'h0000) ? S_ARRECL : S_IDLE;
               ev[EV_OK] = 1'b1;
            end
         end
         S_ARRECL: begin
            // returning fault locks out unless disabled
            if (any_req && st.ctrl[CTRL_ARR_LOCK]) begin
               next_st.fsm = S_LOCK;
            end else if (any_req && st.ctrl[CTRL_EN]) begin
               next_st.req = pri_idx;
               next_st.shot = 2'd0;
               ev[EV_START] = 1'b1;
               next_st.fsm = (cur_shots == 3'd0) ? S_LOCK :
                             arc_go ? S_ARC : S_OPENW;
            end else if (st.tmr >= st.arrecl) begin
               next_st.fsm = S_IDLE;
            end
         end
         S_LOCK: begin
            if (BRK_OPEN_IN) begin
               next_st.trip_done = 1'b1;
            end
            if (lock_exit) begin
               next_st.fsm = S_IDLE;
            end
         end
      endcase
      if (abort) begin
         next_st.fsm = S_LOCK;
      end
      ev[EV_FAIL] = BRK_ACK_FAIL_IN && running;
      if (next_st.fsm == S_LOCK && st.fsm != S_LOCK) begin
         next_st.trip_done = BRK_OPEN_IN;
         ev[EV_LOCK] = 1'b1;
      end
      if (next_st.fsm != st.fsm) begin
         next_st.tmr = 16'h0000;
         next_st.div = 16'h0000; // tick restarts too, no short first ms
      end
      // bus: read data captured in the wait cycle
      next_st.ack = access && !st.ack;
      if (AVS_READ_IN && !st.ack) begin
         unique case (AVS_ADDRESS_IN)
            OFS_CTRL: next_st.rdata = {28'h000_0000, st.ctrl};
            OFS_SHOTS: next_st.rdata = {17'h0_0000, st.shots};
            OFS_ARC: next_st.rdata = {16'h0000, st.arc};
            OFS_RECLAIM: next_st.rdata = {st.arrecl, st.recl};
            OFS_STATE: next_st.rdata = {22'h00_0000, BRK_WAIT_IN,
                                        st.trip_done, st.shot, st.req,
                                        st.fsm};
            OFS_IRQ_STS: next_st.rdata = {27'h000_0000, st.sts};
            OFS_IRQ_MASK: next_st.rdata = {27'h000_0000, st.mask};
            default: next_st.rdata = 32'h0000_0000;
         endcase
      end
      // bus writes take effect at the edge with waitrequest low
      if (AVS_WRITE_IN && done) begin
         unique case (AVS_ADDRESS_IN)
            OFS_CTRL: next_st.ctrl = AVS_WRITEDATA_IN[3:0];
            OFS_SHOTS: next_st.shots = AVS_WRITEDATA_IN[14:0];
            OFS_ARC: next_st.arc = AVS_WRITEDATA_IN[15:0];
            OFS_RECLAIM: begin
               next_st.recl = AVS_WRITEDATA_IN[15:0];
               next_st.arrecl = AVS_WRITEDATA_IN[31:16];
            end
            OFS_IRQ_STS: clr = AVS_WRITEDATA_IN[4:0];
            OFS_IRQ_MASK: next_st.mask = AVS_WRITEDATA_IN[4:0];
            OFS_CMD: next_st.sw_rst = AVS_WRITEDATA_IN[0];
            default: next_st.sw_rst = 1'b0;
         endcase
      end
      // sticky events, a new event beats a same-cycle clear
      next_st.sts = (st.sts & ~clr) | ev;
   end

   // single state register
   always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
         st <= '0;
         st.ctrl <= CTRL_RESET;
      end else begin
         st <= next_st;
      end
   end

   // commands only towards the breaker object
   assign BRK_OPEN_CMD_OUT = (st.fsm == S_OPENW && st.ctrl[CTRL_ARC]) ||
                             (st.fsm == S_LOCK && !st.trip_done);
   // closing only from the close-wait state, never in lock-out
   assign BRK_CLOSE_CMD_OUT = (st.fsm == S_CLOSEW);
   assign FINAL_TRIP_OUT = (st.fsm == S_LOCK) && !st.trip_done;
   assign LOCKOUT_OUT = (st.fsm == S_LOCK);
   assign RECLAIM_OUT = (st.fsm == S_ARRECL);
   // indications vanish outside a running sequence
   assign RUNNING_OUT = running;
   assign REQUESTED_OUT = running ? 5'(5'h01 << st.req) : 5'h00;
   assign SHOT_RUN_OUT = running ? 4'(4'h1 << st.shot) : 4'h0;
   assign IRQ_OUT = |(st.sts & st.mask);

   // checks
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RESET_IN);
   property p_prio;
      st.fsm == S_IDLE && any_req && st.ctrl[CTRL_EN] && !abort &&
         cur_shots != 3'd0 |=> st.req == $past(pri_idx) && running;
   endproperty
   a_prio: assert property (p_prio) else $error("wrong request");
   property p_crit;
      CRITICAL_REQ_IN && running |=> LOCKOUT_OUT && !RUNNING_OUT;
   endproperty
   a_crit: assert property (p_crit) else $error("critical ignored");
   property p_highset;
      HIGHSET_OC_IN |=> st.fsm == S_LOCK;
   endproperty
   a_highset: assert property (p_highset) else $error("no lock");
   property p_dead;
      st.fsm == S_DEAD && st.tmr < dead_ms && !abort |=> !BRK_CLOSE_CMD_OUT;
   endproperty
   a_dead: assert property (p_dead) else $error("early close");
   property p_hold;
      st.fsm == S_LOCK && !lock_exit |=> st.fsm == S_LOCK &&
         !BRK_CLOSE_CMD_OUT;
   endproperty
   a_hold: assert property (p_hold) else $error("left lock-out");
   property p_exit;
      st.fsm == S_LOCK && MANUAL_RESET_IN && !CRITICAL_REQ_IN &&
         !HIGHSET_OC_IN |=> st.fsm == S_IDLE;
   endproperty
   a_exit: assert property (p_exit) else $error("reset ignored");
   property p_wait;
      st.fsm == S_CLOSEW && !BRK_ACK_OK_IN && !abort
         |=> BRK_CLOSE_CMD_OUT;
   endproperty
   a_wait: assert property (p_wait) else $error("close dropped");
   property p_fail;
      BRK_ACK_FAIL_IN && running |=> LOCKOUT_OUT ##1 LOCKOUT_OUT;
   endproperty
   a_fail: assert property (p_fail) else $error("fail ignored");
   property p_next;
      st.fsm == S_RECL && any_req && more && !st.ctrl[CTRL_RCL_FINAL] &&
         !abort |=> st.shot == $past(st.shot) + 2'd1 && running;
   endproperty
   a_next: assert property (p_next) else $error("no next shot");
   property p_last;
      st.fsm == S_RECL && any_req && !more |=> LOCKOUT_OUT && !RUNNING_OUT;
   endproperty
   a_last: assert property (p_last) else $error("no final trip");
   property p_zero;
      st.fsm == S_IDLE && any_req && st.ctrl[CTRL_EN] && st.arc == 16'h0000
         |=> st.fsm != S_ARC;
   endproperty
   a_zero: assert property (p_zero) else $error("zero not skipped");
   property p_arc;
      st.fsm == S_IDLE && any_req && st.ctrl[CTRL_EN] && cur_shots != 3'd0 &&
         arc_go && !abort |=> st.fsm == S_ARC;
   endproperty
   a_arc: assert property (p_arc) else $error("no arcing delay");
   property p_arr;
      st.fsm == S_ARRECL && any_req && st.ctrl[CTRL_ARR_LOCK] |=> LOCKOUT_OUT;
   endproperty
   a_arr: assert property (p_arr) else $error("reclaim no lock");
   property p_cmd;
      BRK_OPEN_CMD_OUT |-> st.fsm inside {S_OPENW, S_LOCK};
   endproperty
   a_cmd: assert property (p_cmd) else $error("stray open");
   c_shot2: cover property (st.fsm == S_RECL ##1 st.shot == 2'd1);
   c_ok: cover property (st.fsm == S_RECL ##1 st.fsm == S_ARRECL);
   c_lock: cover property (st.fsm == S_LOCK ##1 st.fsm == S_IDLE);
endmodule // arsq_top

// file: arsq_brk_model.sv
// breaker object model: status, wait state and acknowledgements
`timescale 1ns/100ps
module arsq_brk_model (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // commands from sequencer, protection stage and operator
   input wire logic open_cmd_in,
   input wire logic close_cmd_in,
   input wire logic stage_trip_in,
   input wire logic oper_close_in,
   // behaviour knobs set by the bench
   input wire logic fail_mode_in,
   input wire logic [7:0] delay_in,
   // object outputs towards the sequencer
   output logic open_out,
   output logic closed_out,
   output logic wait_out,
   output logic ack_ok_out,
   output logic ack_fail_out
);
   logic [7:0] cnt;
   assign open_out = !closed_out;
   always @(posedge clk_in) begin
      ack_ok_out <= 1'b0;
      ack_fail_out <= 1'b0;
      if (reset_in) begin
         closed_out <= 1'b1;
         cnt <= 8'h00;
         wait_out <= 1'b0;
      end else if (closed_out && (open_cmd_in || stage_trip_in)) begin
         // open may be delayed, shown as wait state meanwhile
         wait_out <= (cnt < delay_in);
         cnt <= (cnt < delay_in) ? cnt + 8'h01 : 8'h00;
         if (cnt >= delay_in) closed_out <= 1'b0;
      end else if (!closed_out && (close_cmd_in || oper_close_in)) begin
         wait_out <= (cnt < delay_in);
         cnt <= (cnt < delay_in) ? cnt + 8'h01 : 8'h00;
         // failure time-out leaves the breaker open
         if (cnt >= delay_in && fail_mode_in) ack_fail_out <= 1'b1;
         if (cnt >= delay_in && !fail_mode_in) begin
            closed_out <= 1'b1;
            ack_ok_out <= 1'b1;
         end
      end else begin
         cnt <= 8'h00;
         wait_out <= 1'b0;
      end
   end
endmodule // arsq_brk_model

// file: tb.sv
// self-checking bench for the reclose sequencer
`timescale 1ns/100ps
module tb;
   import arsq_pkg::*;
   localparam int unsigned TK = 4;
   localparam logic [31:0] M = 32'hFFFF_FFFF;
   localparam logic [13:0] P = 14'h3FFF;
   typedef struct {
      logic [31:0] e;
      logic [31:0] m;
      logic [13:0] p;
      logic [13:0] pm;
   } arsq_note_t;
   // design side signals
   logic clk = 1'b0, rst = 1'b1, rd_en = 1'b0, wr_en = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000, rdat;
   logic [NREQ-1:0] req = 5'h00, reqd;
   logic [NSHOT-1:0] shot;
   logic crit = 1'b0, hs = 1'b0, mrst = 1'b0, wreq, irq, ocmd, ccmd;
   logic b_open, b_closed, b_wait, b_ok, b_fail, run, ftrip, lock, rcl;
   // partner knobs
   logic trip = 1'b0, oper = 1'b0, fail = 1'b0;
   logic [7:0] dly = 8'h08;
   // bookkeeping
   arsq_note_t rq[$];
   int cq_lo[$], cq_hi[$];
   int err_total = 0, num_checks = 0, ocnt = 0, da, db;
   logic popen = 1'b0, pccmd = 1'b0;
   wire logic [13:0] pv = {irq, lock, ftrip, run, rcl, reqd, shot};

   always #12.5 clk = ~clk;

   arsq_top #(.TICK_CYCLES(TK)) u_arsq_top (
      .CLK_IN(clk), .RESET_IN(rst), .AVS_ADDRESS_IN(adr),
      .AVS_READ_IN(rd_en), .AVS_WRITE_IN(wr_en), .AVS_WRITEDATA_IN(wdat),
      .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wreq), .IRQ_OUT(irq),
      .RECLOSE_REQ_IN(req), .CRITICAL_REQ_IN(crit), .HIGHSET_OC_IN(hs),
      .MANUAL_RESET_IN(mrst), .BRK_OPEN_IN(b_open), .BRK_CLOSED_IN(b_closed),
      .BRK_WAIT_IN(b_wait), .BRK_ACK_OK_IN(b_ok), .BRK_ACK_FAIL_IN(b_fail),
      .BRK_OPEN_CMD_OUT(ocmd), .BRK_CLOSE_CMD_OUT(ccmd), .RUNNING_OUT(run),
      .FINAL_TRIP_OUT(ftrip), .LOCKOUT_OUT(lock), .RECLAIM_OUT(rcl),
      .REQUESTED_OUT(reqd), .SHOT_RUN_OUT(shot));

   arsq_brk_model u_arsq_brk_model (
      .clk_in(clk), .reset_in(rst), .open_cmd_in(ocmd), .close_cmd_in(ccmd),
      .stage_trip_in(trip), .oper_close_in(oper), .fail_mode_in(fail),
      .delay_in(dly), .open_out(b_open), .closed_out(b_closed),
      .wait_out(b_wait), .ack_ok_out(b_ok), .ack_fail_out(b_fail));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic give_up();
      err_total++;
      conclude();
   endtask

   // one avalon access, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      @(posedge clk);
      adr <= a;
      wdat <= d;
      wr_en <= w;
      rd_en <= !w;
      // waitrequest sampled at the rising edge that takes the access
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (wreq === 1'b0) break;
      end
      if (n == 40) give_up();
      wr_en <= 1'b0;
      rd_en <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
         input logic [31:0] m, input logic [13:0] p, input logic [13:0] pm);
      rq.push_back('{e, m, p, pm});
      bus(1'b0, a, 32'h0000_0000);
   endtask

   task automatic wait_for(ref logic s, input logic v);
      int n;
      for (n = 0; n < 3000; n++) begin
         if (s === v) break;
         @(posedge clk);
      end
      if (n == 3000) give_up();
   endtask

   // close window in cycles after the breaker is seen open
   task automatic expect_close(input int l);
      cq_lo.push_back(l * TK);
      cq_hi.push_back((l + 1) * TK + 3);
   endtask

   task automatic pulse_reset();
      @(posedge clk);
      mrst <= 1'b1;
      @(posedge clk);
      mrst <= 1'b0;
   endtask

   // operator closes the breaker outside any sequence
   task automatic reclose_brk();
      @(posedge clk);
      oper <= 1'b1;
      wait_for(b_closed, 1'b1);
      @(posedge clk);
      oper <= 1'b0;
   endtask

   // shot: wait open, drop the request, wait for the close to finish
   task automatic run_shot(input int l);
      expect_close(l);
      wait_for(b_open, 1'b1);
      @(posedge clk);
      req <= 5'h00;
      trip <= 1'b0;
      wait_for(ccmd, 1'b1);
      wait_for(ccmd, 1'b0);
   endtask

   // monitor: every taken read and every close command against a note
   always @(posedge clk) begin
      arsq_note_t n;
      if (rd_en && wreq === 1'b0) begin
         if (rq.size() == 0) check(32'h0000_0001, 32'h0000_0000);
         else begin
            n = rq.pop_front();
            check(rdat & n.m, n.e & n.m);
            check({18'h0_0000, pv & n.pm}, {18'h0_0000, n.p & n.pm});
         end
      end
      if (ccmd && !pccmd) begin
         if (cq_lo.size() == 0) check(32'h0000_0001, 32'h0000_0000);
         else begin
            check({31'h0, ocnt >= cq_lo[0] && ocnt <= cq_hi[0]}, 32'h1);
            void'(cq_lo.pop_front());
            void'(cq_hi.pop_front());
         end
      end
      ocnt = (b_open && !popen) ? 0 : ocnt + 1;
      popen = b_open;
      pccmd = ccmd;
   end

   initial begin
      void'($urandom(32'haf2c));
      da = $urandom_range(3, 1);
      db = $urandom_range(3, 1);
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      // reset values and an unmapped place
      rd(OFS_CTRL, 32'h0000_0009, M, 14'h0000, P);
      bus(1'b1, 8'h30, M);
      rd(8'h30, 32'h0000_0000, M, 14'h0000, P);
      bus(1'b1, OFS_CTRL, 32'h0000_0001);
      bus(1'b1, OFS_SHOTS, 32'h0000_1011);
      bus(1'b1, 8'h50, 32'(da));
      bus(1'b1, 8'h54, 32'(db));
      bus(1'b1, OFS_RECLAIM, 32'h0000_0032);
      rd(OFS_SHOTS, 32'h0000_1011, M, 14'h0000, P);
      // two requests at once, stage trips the breaker itself
      @(posedge clk);
      req <= 5'h0A;
      trip <= 1'b1;
      dly <= 8'($urandom_range(8, 5));
      rd(OFS_STATE, 32'h0000_020B, 32'h0000_02FF, 14'h0421, P);
      run_shot(da);
      rd(OFS_STATE, 32'h0000_000F, 32'h0000_00FF, 14'h0421, P);
      // fault back during shot reclaim: second shot
      @(posedge clk);
      req <= 5'h02;
      trip <= 1'b1;
      rd(OFS_STATE, 32'h0000_024B, 32'h0000_02FF, 14'h0422, P);
      run_shot(db);
      // no shot left: final trip, indications dropped
      @(posedge clk);
      req <= 5'h02;
      trip <= 1'b1;
      rd(OFS_STATE, 32'h0000_0004, 32'h0000_0007, 14'h1800, P);
      wait_for(b_open, 1'b1);
      @(posedge clk);
      req <= 5'h00;
      trip <= 1'b0;
      repeat (20) @(posedge clk);
      pulse_reset();
      rd(OFS_STATE, 32'h0000_0000, 32'h0000_0007, 14'h0000, P);
      reclose_brk();
      // own arcing delay, zero dead time, overall reclaim lock
      bus(1'b1, OFS_CTRL, 32'h0000_000B);
      bus(1'b1, OFS_ARC, 32'h0000_0001);
      bus(1'b1, 8'h40, 32'h0000_0000);
      bus(1'b1, OFS_RECLAIM, 32'h0028_0002);
      bus(1'b1, OFS_IRQ_MASK, 32'h0000_0004);
      bus(1'b1, OFS_IRQ_STS, 32'h0000_001F);
      @(posedge clk);
      req <= 5'h11;
      dly <= 8'h02;
      rd(OFS_STATE, 32'h0000_0001, 32'h0000_003F, 14'h0411, P);
      run_shot(0);
      wait_for(rcl, 1'b1);
      rd(OFS_STATE, 32'h0000_0005, 32'h0000_0007, 14'h0200, P);
      @(posedge clk);
      req <= 5'h04;
      rd(OFS_STATE, 32'h0000_0004, 32'h0000_0007, 14'h3000, 14'h37FF);
      rd(OFS_IRQ_STS, 32'h0000_000D, 32'h0000_001D, 14'h0000, 14'h0000);
      bus(1'b1, OFS_IRQ_STS, 32'h0000_0004);
      rd(OFS_IRQ_STS, 32'h0000_0009, 32'h0000_001D, 14'h0000, 14'h2000);
      @(posedge clk);
      req <= 5'h00;
      bus(1'b1, OFS_CMD, 32'h0000_0001);
      rd(OFS_STATE, 32'h0000_0000, 32'h0000_0007, 14'h0000, P);
      reclose_brk();
      // high-set in idle, left by closing the breaker
      @(posedge clk);
      hs <= 1'b1;
      rd(OFS_STATE, 32'h0000_0004, 32'h0000_0007, 14'h1000, 14'h17FF);
      wait_for(b_open, 1'b1);
      @(posedge clk);
      hs <= 1'b0;
      reclose_brk();
      rd(OFS_STATE, 32'h0000_0000, 32'h0000_0007, 14'h0000, 14'h1FFF);
      // critical request in mid dead time
      bus(1'b1, OFS_CTRL, 32'h0000_0001);
      bus(1'b1, 8'h80, 32'h0000_0005);
      @(posedge clk);
      req <= 5'h10;
      trip <= 1'b1;
      wait_for(b_open, 1'b1);
      @(posedge clk);
      req <= 5'h00;
      trip <= 1'b0;
      repeat (4) @(posedge clk);
      crit <= 1'b1;
      rd(OFS_STATE, 32'h0000_0004, 32'h0000_0007, 14'h1000, 14'h17FF);
      @(posedge clk);
      crit <= 1'b0;
      pulse_reset();
      reclose_brk();
      // failure acknowledgement on close
      bus(1'b1, 8'h80, 32'h0000_0001);
      bus(1'b1, OFS_IRQ_STS, 32'h0000_001F);
      @(posedge clk);
      req <= 5'h10;
      trip <= 1'b1;
      fail <= 1'b1;
      run_shot(1);
      repeat (10) @(posedge clk);
      rd(OFS_IRQ_STS, 32'h0000_0015, 32'h0000_001D, 14'h1000, 14'h17FF);
      @(posedge clk);
      fail <= 1'b0;
      pulse_reset();
      rd(OFS_STATE, 32'h0000_0000, 32'h0000_0007, 14'h0000, 14'h1FFF);
      // reclaim-final set: fault back during shot reclaim locks at once
      reclose_brk();
      bus(1'b1, OFS_CTRL, 32'h0000_0005);
      @(posedge clk);
      req <= 5'h02;
      trip <= 1'b1;
      run_shot(da);
      @(posedge clk);
      req <= 5'h02;
      trip <= 1'b1;
      rd(OFS_STATE, 32'h0000_0004, 32'h0000_0007, 14'h1000, 14'h17FF);
      wait_for(b_open, 1'b1);
      @(posedge clk);
      req <= 5'h00;
      trip <= 1'b0;
      conclude();
   end
endmodule // tb
